// *** verilog/fu_pkg.sv ***
// Package with the address map, field layouts and types of the field unit data map.
`default_nettype none

package fu_pkg;

  // Number of field units held in the map.
  localparam int FU_UNITS = 60;

  // Register numbers of each block's parameter 0 for unit 1; unit n sits at base + (n - 1).
  localparam logic [15:0] FU_ALARM_BASE = 16'h06a0;
  localparam logic [15:0] FU_FEEDBACK_BASE = 16'h0880;
  localparam logic [15:0] FU_DEMAND_BASE = 16'h0a9c;
  localparam logic [15:0] FU_RELAY_RB_BASE = 16'h0c40;
  localparam logic [15:0] FU_OPEN_BASE = 16'h0c7c;
  localparam logic [15:0] FU_STOP_BASE = 16'h0cb8;
  localparam logic [15:0] FU_CLOSE_BASE = 16'h0cf4;
  localparam logic [15:0] FU_SHUTDOWN_BASE = 16'h0d30;
  localparam logic [15:0] FU_STROKE_BASE = 16'h0d6c;

  // Span of the nine blocks; every word inside it that is not defined reads as zero.
  localparam logic [15:0] FU_MAP_START = 16'h06a0;
  localparam logic [15:0] FU_MAP_END = 16'h0e20;

  // Discrete bit numbers of bit 0 for unit 1; unit n bit b sits at base + 16*(n - 1) + b.
  localparam logic [15:0] FU_DISC_ALARM_BASE = 16'h0b40;
  localparam logic [15:0] FU_DISC_RELAY_BASE = 16'h1680;
  localparam logic [15:0] FU_DISC_SPAN = 16'h03c0;

  // Defined word bases in the order of the word areas below.
  localparam logic [7:0][15:0] FU_WORD_BASE = {
    FU_STROKE_BASE, FU_SHUTDOWN_BASE, FU_CLOSE_BASE, FU_STOP_BASE,
    FU_OPEN_BASE, FU_RELAY_RB_BASE, FU_DEMAND_BASE, FU_ALARM_BASE
  };
  localparam logic [15:0] FU_UNIT_COUNT = 16'h003c;

  // Position scaling: standard span and the 12-bit alternative span.
  localparam logic [15:0] FU_POS_FULL_STD = 16'h7fff;
  localparam logic [15:0] FU_POS_FULL_ALT = 16'h0fff;
  localparam int FU_POS_ALT_SHIFT = 3;

  // Command word value that de-energises; anything else energises.
  localparam logic [15:0] FU_CMD_DEENERGISE = 16'h0000;
  localparam logic [15:0] FU_WORD_RESET = 16'h0000;

  // Alarm word bit positions.
  localparam int FU_AB_MEMORY = 0;
  localparam int FU_AB_COMMS = 1;
  localparam int FU_AB_CONTROL = 2;
  localparam int FU_AB_POWER_ON = 3;
  localparam int FU_AB_WATCHDOG = 4;
  localparam int FU_AB_MONITOR = 5;
  localparam int FU_AB_THERMOSTAT = 6;
  localparam int FU_AB_LOCAL_STOP = 7;
  localparam int FU_AB_START_STOP = 8;
  localparam int FU_AB_OBSTRUCTED = 9;
  localparam int FU_AB_JAMMED = 10;
  localparam int FU_AB_HAND_OPEN = 11;
  localparam int FU_AB_HAND_CLOSE = 12;
  localparam int FU_AB_HAND_OPENING = 13;
  localparam int FU_AB_HAND_CLOSING = 14;
  localparam int FU_AB_OVERRUN = 15;

  // Relay readback bit positions.
  localparam int FU_RB_SHUTDOWN = 0;
  localparam int FU_RB_CLOSE = 1;
  localparam int FU_RB_STOP = 2;
  localparam int FU_RB_OPEN = 3;
  localparam int FU_RB_ACTION = 7;

  // Unit type decides how the shared alarm bits are interpreted.
  typedef enum logic [1:0] {
    FU_TYPE_STD = 2'b00,
    FU_TYPE_HAND = 2'b01,
    FU_TYPE_FAULT = 2'b10,
    FU_TYPE_BASIC = 2'b11
  } fu_utype_t;

  typedef enum logic [3:0] {
    FU_AREA_NONE = 4'h0,
    FU_AREA_RESERVED = 4'h1,
    FU_AREA_ALARM = 4'h2,
    FU_AREA_DEMAND = 4'h3,
    FU_AREA_RELAY_RB = 4'h4,
    FU_AREA_OPEN = 4'h5,
    FU_AREA_STOP = 4'h6,
    FU_AREA_CLOSE = 4'h7,
    FU_AREA_SHUTDOWN = 4'h8,
    FU_AREA_STROKE = 4'h9,
    FU_AREA_FEEDBACK = 4'ha,
    FU_AREA_DISC_ALARM = 4'hb,
    FU_AREA_DISC_RELAY = 4'hc
  } fu_area_t;

  typedef struct packed {
    logic memory_failure_flag;
    logic comms_failure_flag;
    logic not_remote_flag;
    logic control_unavailable_flag;
    logic power_on_reset_flag;
    logic watchdog_failure_flag;
    logic monitor_relay_flag;
    logic thermostat_trip_flag;
    logic local_stop_flag;
    logic start_stop_failure_flag;
    logic valve_obstructed_flag;
    logic valve_jammed_flag;
    logic hand_open_flag;
    logic hand_close_flag;
    logic hand_opening_flag;
    logic hand_closing_flag;
    logic hand_movement_flag;
    logic overrun_at_limit_flag;
  } fu_alarm_raw_t;

  typedef struct packed {
    logic shutdown_relay_state;
    logic close_relay_state;
    logic stop_relay_state;
    logic open_relay_state;
    logic relay_action_mode;
  } fu_relay_t;

  // One update of a unit's state as delivered by the field network.
  typedef struct packed {
    fu_utype_t utype;
    fu_alarm_raw_t alarm;
    logic [14:0] position;
    fu_relay_t relay;
    logic open_limit;
    logic close_limit;
  } fu_field_t;

  typedef struct packed {
    logic open_cmd;
    logic stop_cmd;
    logic close_cmd;
    logic emergency_shutdown_command;
    logic stroke_test_command;
  } fu_cmd_t;

endpackage : fu_pkg

`default_nettype wire

// *** verilog/fu_addr_decode.sv ***
// Address decoder that turns a register or discrete number into an area and a unit index.
`default_nettype none

module fu_addr_decode (
  input wire logic [15:0] addr, // Register or discrete number from the host
  input wire logic discrete, // High for a discrete bit access
  output fu_pkg::fu_area_t area, // Area hit by the access
  output logic [5:0] unit, // Unit index, zero for unit 1
  output logic [3:0] bit_sel // Bit within the unit for discrete accesses
);
  import fu_pkg::*;

  logic [15:0] off;

  always_comb begin
    area = FU_AREA_NONE;
    unit = 6'h00;
    bit_sel = addr[3:0];
    off = 16'h0000;
    if (discrete) begin
      if (addr >= FU_DISC_ALARM_BASE && addr < FU_DISC_ALARM_BASE + FU_DISC_SPAN) begin
        off = addr - FU_DISC_ALARM_BASE;
        area = FU_AREA_DISC_ALARM;
        unit = off[9:4];
      end else if (addr >= FU_DISC_RELAY_BASE && addr < FU_DISC_RELAY_BASE + FU_DISC_SPAN) begin
        off = addr - FU_DISC_RELAY_BASE;
        area = FU_AREA_DISC_RELAY;
        unit = off[9:4];
      end
    end else if (addr >= FU_MAP_START && addr < FU_MAP_END) begin
      // Words of the blocks that are not defined stay reserved and read as zero.
      area = FU_AREA_RESERVED;
      if (addr >= FU_FEEDBACK_BASE && addr < FU_FEEDBACK_BASE + FU_UNIT_COUNT) begin
        off = addr - FU_FEEDBACK_BASE;
        area = FU_AREA_FEEDBACK;
        unit = off[5:0];
      end
      for (int i = 0; i < 8; i++) begin
        if (addr >= FU_WORD_BASE[i] && addr < FU_WORD_BASE[i] + FU_UNIT_COUNT) begin
          off = addr - FU_WORD_BASE[i];
          area = fu_area_t'(4'(i + 2));
          unit = off[5:0];
        end
      end
    end
  end

endmodule : fu_addr_decode

`default_nettype wire

// *** verilog/fu_map.sv ***
// Field unit status and command map served to the host word and discrete access port.
`default_nettype none

module fu_map (
  input wire logic clk, // 125 MHz clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic proto_alt_pin, // High selects the 12-bit position protocol
  input wire logic limit_readback_pin, // High makes open and close reads return limits
  input wire logic host_req, // One-cycle host access request
  input wire logic host_we, // Host access is a write
  input wire logic host_discrete, // Host access addresses a discrete bit
  input wire logic [15:0] host_addr, // Register or discrete number
  input wire logic [15:0] host_wdata, // Write data
  output logic host_ack, // One-cycle answer, one cycle after the request
  output logic host_err, // Answer is an illegal address or a refused write
  output logic [15:0] host_rdata, // Read data, valid with host_ack
  input wire logic fld_we, // One-cycle field update strobe
  input wire logic [5:0] fld_unit, // Unit index of the update, zero for unit 1
  input wire fu_pkg::fu_field_t fld_data, // Unit state from the field network
  output fu_pkg::fu_cmd_t [fu_pkg::FU_UNITS-1:0] cmd_out, // Energise level per relay
  output logic [fu_pkg::FU_UNITS-1:0][15:0] demand_out // Position demand per unit
);
  import fu_pkg::*;

  fu_area_t area;
  logic [5:0] unit;
  logic [3:0] bit_sel;
  logic proto_meta_q;
  logic proto_alt_q;
  logic limit_meta_q;
  logic limit_en_q;
  fu_field_t [FU_UNITS-1:0] field_q;
  logic [FU_UNITS-1:0][15:0] demand_q;
  logic [FU_UNITS-1:0][15:0] open_word_q;
  logic [FU_UNITS-1:0][15:0] stop_word_q;
  logic [FU_UNITS-1:0][15:0] close_word_q;
  logic [FU_UNITS-1:0][15:0] shutdown_word_q;
  logic [FU_UNITS-1:0][15:0] stroke_word_q;
  fu_cmd_t [FU_UNITS-1:0] cmd_q;
  logic [15:0] rdata_d;
  logic err_d;
  logic ack_q;
  logic err_q;
  logic [15:0] rdata_q;
  logic [15:0] alarm_word;
  logic [15:0] relay_word;
  logic [15:0] feedback_word;
  logic unit_ok;
  logic fld_ok;
  logic wr_hit;

  fu_addr_decode u_decode (
    .addr(host_addr),
    .discrete(host_discrete),
    .area(area),
    .unit(unit),
    .bit_sel(bit_sel)
  );

  // Builds the alarm word of one unit from its raw flags and its type.
  function automatic logic [15:0] alarm_of(input fu_field_t f);
    logic [15:0] w;
    logic any_fault;
    w = 16'h0000;
    any_fault = f.alarm.memory_failure_flag | f.alarm.comms_failure_flag |
                f.alarm.watchdog_failure_flag | f.alarm.thermostat_trip_flag |
                f.alarm.start_stop_failure_flag | f.alarm.valve_obstructed_flag |
                f.alarm.valve_jammed_flag | f.alarm.overrun_at_limit_flag;
    w[FU_AB_MEMORY] = f.alarm.memory_failure_flag;
    w[FU_AB_COMMS] = f.alarm.comms_failure_flag;
    w[FU_AB_POWER_ON] = f.alarm.power_on_reset_flag;
    w[FU_AB_WATCHDOG] = f.alarm.watchdog_failure_flag;
    if (f.utype != FU_TYPE_BASIC) begin
      w[FU_AB_MONITOR] = f.alarm.monitor_relay_flag;
      w[FU_AB_LOCAL_STOP] = f.alarm.local_stop_flag;
      w[FU_AB_START_STOP] = f.alarm.start_stop_failure_flag;
      w[FU_AB_OBSTRUCTED] = f.alarm.valve_obstructed_flag;
      w[FU_AB_JAMMED] = f.alarm.valve_jammed_flag;
      w[FU_AB_OVERRUN] = f.alarm.overrun_at_limit_flag;
    end
    case (f.utype)
      FU_TYPE_STD: begin
        w[FU_AB_CONTROL] = f.alarm.not_remote_flag;
        w[FU_AB_THERMOSTAT] = f.alarm.thermostat_trip_flag;
        w[FU_AB_HAND_CLOSING] = f.alarm.hand_movement_flag;
      end
      FU_TYPE_HAND: begin
        w[FU_AB_CONTROL] = f.alarm.control_unavailable_flag;
        w[FU_AB_THERMOSTAT] = f.alarm.thermostat_trip_flag;
        w[FU_AB_HAND_OPEN] = f.alarm.hand_open_flag;
        w[FU_AB_HAND_CLOSE] = f.alarm.hand_close_flag;
        w[FU_AB_HAND_OPENING] = f.alarm.hand_opening_flag;
        w[FU_AB_HAND_CLOSING] = f.alarm.hand_closing_flag;
      end
      FU_TYPE_FAULT: begin
        w[FU_AB_CONTROL] = f.alarm.not_remote_flag;
        w[FU_AB_THERMOSTAT] = any_fault;
        w[FU_AB_HAND_CLOSING] = f.alarm.hand_movement_flag;
      end
      default: begin
        // The basic type supports only the unit health flags; the rest stay zero.
        w[FU_AB_CONTROL] = 1'b0;
      end
    endcase
    return w;
  endfunction : alarm_of

  // Both straps come from pins outside the clock domain, hence the double flop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      proto_meta_q <= 1'b0;
      proto_alt_q <= 1'b0;
      limit_meta_q <= 1'b0;
      limit_en_q <= 1'b0;
    end else begin
      proto_meta_q <= proto_alt_pin;
      proto_alt_q <= proto_meta_q;
      limit_meta_q <= limit_readback_pin;
      limit_en_q <= limit_meta_q;
    end
  end

  // Out-of-range unit indices from the field side are dropped rather than aliased.
  assign fld_ok = fld_unit < 6'(FU_UNITS);
  assign unit_ok = unit < 6'(FU_UNITS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      field_q <= '0;
    end else if (fld_we && fld_ok) begin
      field_q[fld_unit] <= fld_data;
    end
  end

  assign alarm_word = alarm_of(field_q[unit]);

  // Readback of relay states with the fixed relay order and the action flag.
  always_comb begin
    relay_word = 16'h0000;
    relay_word[FU_RB_SHUTDOWN] = field_q[unit].relay.shutdown_relay_state;
    relay_word[FU_RB_CLOSE] = field_q[unit].relay.close_relay_state;
    relay_word[FU_RB_STOP] = field_q[unit].relay.stop_relay_state;
    relay_word[FU_RB_OPEN] = field_q[unit].relay.open_relay_state;
    relay_word[FU_RB_ACTION] = field_q[unit].relay.relay_action_mode;
  end

  // The 15-bit travel fraction is the standard span as is, and shifted for 12 bits.
  always_comb begin
    if (proto_alt_q) begin
      feedback_word = 16'({1'b0, field_q[unit].position} >> FU_POS_ALT_SHIFT) & FU_POS_FULL_ALT;
    end else begin
      feedback_word = {1'b0, field_q[unit].position} & FU_POS_FULL_STD;
    end
  end

  assign wr_hit = host_req && host_we && unit_ok;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      demand_q <= '0;
      open_word_q <= '0;
      stop_word_q <= '0;
      close_word_q <= '0;
      shutdown_word_q <= '0;
      stroke_word_q <= '0;
    end else if (wr_hit) begin
      case (area)
        FU_AREA_DEMAND: demand_q[unit] <= host_wdata;
        FU_AREA_OPEN: open_word_q[unit] <= host_wdata;
        FU_AREA_STOP: stop_word_q[unit] <= host_wdata;
        FU_AREA_CLOSE: close_word_q[unit] <= host_wdata;
        FU_AREA_SHUTDOWN: shutdown_word_q[unit] <= host_wdata;
        FU_AREA_STROKE: stroke_word_q[unit] <= host_wdata;
        default: begin
        end
      endcase
    end
  end

  // Relay drive levels, registered so the outputs never glitch during decode.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= '0;
    end else if (wr_hit) begin
      case (area)
        FU_AREA_OPEN: cmd_q[unit].open_cmd <= host_wdata != FU_CMD_DEENERGISE;
        FU_AREA_STOP: cmd_q[unit].stop_cmd <= host_wdata != FU_CMD_DEENERGISE;
        FU_AREA_CLOSE: cmd_q[unit].close_cmd <= host_wdata != FU_CMD_DEENERGISE;
        FU_AREA_SHUTDOWN: begin
          cmd_q[unit].emergency_shutdown_command <= host_wdata != FU_CMD_DEENERGISE;
        end
        FU_AREA_STROKE: begin
          cmd_q[unit].stroke_test_command <= host_wdata != FU_CMD_DEENERGISE;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data and error of the current access; reserved words read zero.
  always_comb begin
    rdata_d = 16'h0000;
    err_d = 1'b0;
    case (area)
      FU_AREA_NONE: err_d = 1'b1;
      FU_AREA_RESERVED: rdata_d = FU_WORD_RESET;
      FU_AREA_ALARM: begin
        rdata_d = alarm_word;
        err_d = host_we;
      end
      FU_AREA_FEEDBACK: begin
        rdata_d = feedback_word;
        err_d = host_we;
      end
      FU_AREA_DEMAND: rdata_d = demand_q[unit];
      FU_AREA_RELAY_RB: begin
        rdata_d = relay_word;
        err_d = host_we;
      end
      FU_AREA_OPEN: begin
        rdata_d = limit_en_q ? {15'h0000, field_q[unit].open_limit} : open_word_q[unit];
      end
      FU_AREA_STOP: rdata_d = stop_word_q[unit];
      FU_AREA_CLOSE: begin
        rdata_d = limit_en_q ? {15'h0000, field_q[unit].close_limit} : close_word_q[unit];
      end
      FU_AREA_SHUTDOWN: rdata_d = shutdown_word_q[unit];
      FU_AREA_STROKE: rdata_d = stroke_word_q[unit];
      FU_AREA_DISC_ALARM: begin
        rdata_d = {15'h0000, alarm_word[bit_sel]};
        err_d = host_we;
      end
      FU_AREA_DISC_RELAY: begin
        rdata_d = {15'h0000, relay_word[bit_sel]};
        err_d = host_we;
      end
      default: err_d = 1'b1;
    endcase
    if (!unit_ok) begin
      err_d = 1'b1;
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= host_req;
      if (host_req) begin
        err_q <= err_d;
        rdata_q <= host_we ? 16'h0000 : rdata_d;
      end
    end
  end

  assign host_ack = ack_q;
  assign host_err = err_q;
  assign host_rdata = rdata_q;
  assign cmd_out = cmd_q;
  assign demand_out = demand_q;

endmodule : fu_map

`default_nettype wire

// *** bench/fu_host_model.sv ***
// Host side model that issues one-cycle word and discrete accesses and collects the answers.
`default_nettype none

module fu_host_model (
  input wire logic clk, // Clock
  output logic host_req, // Request pulse
  output logic host_we, // Access is a write
  output logic host_discrete, // Access is a discrete bit
  output logic [15:0] host_addr, // Register or discrete number
  output logic [15:0] host_wdata, // Write data
  input wire logic host_ack, // Answer strobe
  input wire logic host_err, // Answer is a refusal
  input wire logic [15:0] host_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    host_req = 1'b0;
    host_we = 1'b0;
    host_discrete = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
  end

  // Runs from a falling edge; req stays up for back-to-back calls.
  task automatic xfer(input logic we, input logic disc, input logic [15:0] a,
    input logic [15:0] wd, output logic ack, output logic err, output logic [15:0] rdat);
    host_req = 1'b1;
    host_we = we;
    host_discrete = disc;
    host_addr = a;
    host_wdata = wd;
    @(negedge clk);
    ack = host_ack;
    err = host_err;
    rdat = host_rdata;
  endtask : xfer

  // Inverted idle lines keep stale values from passing as live.
  task automatic idle();
    host_req = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask : idle

endmodule : fu_host_model

`default_nettype wire

// *** bench/fu_map_assertions.sv ***
// Concurrent checks on the ports of the field unit map.
`default_nettype none

module fu_map_chk (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic host_req, // Request pulse
  input wire logic host_we, // Write access
  input wire logic host_discrete, // Discrete access
  input wire logic [15:0] host_addr, // Access number
  input wire logic [15:0] host_wdata, // Write data
  input wire logic host_ack, // Answer strobe
  input wire logic host_err, // Refusal flag
  input wire logic [15:0] host_rdata, // Read data
  input wire fu_pkg::fu_cmd_t [fu_pkg::FU_UNITS-1:0] cmd_out, // Relay levels
  input wire logic [fu_pkg::FU_UNITS-1:0][15:0] demand_out // Demand words
);
  import fu_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic wr_word;
  assign wr_word = host_req && host_we && !host_discrete;

  a_ack_follows: assert property (host_req |=> host_ack)
    else $error("no answer after request");
  a_ack_only_after: assert property (!host_req |=> !host_ack)
    else $error("answer without a request");
  a_open_energise: assert property (wr_word && host_addr == FU_OPEN_BASE &&
    host_wdata != 16'h0000 |=> cmd_out[0].open_cmd)
    else $error("open not energised");
  a_esd_deenergise: assert property (wr_word && host_addr == FU_SHUTDOWN_BASE + 16'h003b &&
    host_wdata == 16'h0000 |=> !cmd_out[59].emergency_shutdown_command)
    else $error("shutdown not de-energised");
  a_demand_store: assert property (wr_word && host_addr == FU_DEMAND_BASE |=>
    demand_out[0] == $past(host_wdata) && !host_err)
    else $error("demand word not stored");
  a_ro_refused: assert property (wr_word && host_addr == FU_FEEDBACK_BASE |=>
    host_err && host_rdata == 16'h0000)
    else $error("feedback write not refused");
  a_disc_write_refused: assert property (host_req && host_we && host_discrete |=> host_err)
    else $error("discrete write not refused");
  a_reserved_zero: assert property (host_req && !host_we && !host_discrete &&
    host_addr == 16'h06dc |=> host_rdata == 16'h0000 && !host_err)
    else $error("reserved word not zero");
  a_below_map: assert property (host_req && !host_discrete && host_addr < FU_MAP_START |=>
    host_err)
    else $error("access below map not refused");
  a_outputs_hold: assert property (!host_req |=> $stable(cmd_out) && $stable(demand_out))
    else $error("outputs changed without write");
  a_answer_hold: assert property (!host_ack |-> $stable(host_rdata) && $stable(host_err))
    else $error("answer changed without ack");

  c_back_to_back: cover property (wr_word ##1 wr_word);
  c_disc_read: cover property (host_req && host_discrete && !host_we ##1 host_ack);
  c_refusal: cover property (host_ack && host_err);

endmodule : fu_map_chk

`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the field unit map against a model of its contents.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fu_pkg::*;

  logic clk, reset_n, proto_alt_pin, limit_readback_pin, fld_we, ok, er;
  logic host_req, host_we, host_discrete, host_ack, host_err;
  logic [15:0] host_addr, host_wdata, host_rdata, rd, exp_w, rb_w;
  logic [5:0] fld_unit;
  logic [63:0] rnd;
  fu_field_t fld_data;
  fu_cmd_t [FU_UNITS-1:0] cmd_out;
  logic [FU_UNITS-1:0][15:0] demand_out;
  fu_field_t fld_m[FU_UNITS];
  logic [15:0] cmd_m[5][FU_UNITS];
  logic [15:0] cbase[5];
  int n_mismatch, total_checks, u;

  fu_map i_dut (.clk(clk), .reset_n(reset_n), .proto_alt_pin(proto_alt_pin),
    .limit_readback_pin(limit_readback_pin), .host_req(host_req), .host_we(host_we),
    .host_discrete(host_discrete), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_err(host_err), .host_rdata(host_rdata), .fld_we(fld_we),
    .fld_unit(fld_unit), .fld_data(fld_data), .cmd_out(cmd_out), .demand_out(demand_out));
  fu_host_model i_host (.clk(clk), .host_req(host_req), .host_we(host_we),
    .host_discrete(host_discrete), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_err(host_err), .host_rdata(host_rdata));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [15:0] ad(input logic [15:0] base, input int off);
    return base + 16'(off);
  endfunction : ad

  function automatic logic [15:0] exp_alarm(input fu_field_t f);
    logic [15:0] w;
    fu_alarm_raw_t a;
    a = f.alarm;
    w = 16'h0000;
    w[0] = a.memory_failure_flag;
    w[1] = a.comms_failure_flag;
    w[3] = a.power_on_reset_flag;
    w[4] = a.watchdog_failure_flag;
    if (f.utype != FU_TYPE_BASIC) begin
      w[2] = a.not_remote_flag;
      w[6:5] = {a.thermostat_trip_flag, a.monitor_relay_flag};
      w[8:7] = {a.start_stop_failure_flag, a.local_stop_flag};
      w[10:9] = {a.valve_jammed_flag, a.valve_obstructed_flag};
      w[14] = a.hand_movement_flag;
      w[15] = a.overrun_at_limit_flag;
    end
    if (f.utype == FU_TYPE_HAND) begin
      w[2] = a.control_unavailable_flag;
      w[14:11] = {a.hand_closing_flag, a.hand_opening_flag, a.hand_close_flag,
        a.hand_open_flag};
    end
    if (f.utype == FU_TYPE_FAULT)
      w[6] = a.memory_failure_flag | a.comms_failure_flag | a.watchdog_failure_flag |
        a.thermostat_trip_flag | a.start_stop_failure_flag | a.valve_obstructed_flag |
        a.valve_jammed_flag | a.overrun_at_limit_flag;
    return w;
  endfunction : exp_alarm

  function automatic logic [15:0] exp_rb(input fu_relay_t r);
    return {8'h00, r.relay_action_mode, 3'b000, r.open_relay_state, r.stop_relay_state,
      r.close_relay_state, r.shutdown_relay_state};
  endfunction : exp_rb

  task automatic rd_chk(input string nm, input logic disc, input logic [15:0] a,
    input logic [15:0] exp);
    i_host.xfer(1'b0, disc, a, 16'h0000, ok, er, rd);
    chk({nm, " ack"}, {15'h0000, ok}, 16'h0001);
    chk({nm, " err"}, {15'h0000, er}, 16'h0000);
    chk(nm, rd, exp);
  endtask : rd_chk

  task automatic ref_chk(input logic we, input logic disc, input logic [15:0] a, input logic e);
    i_host.xfer(we, disc, a, 16'hff00, ok, er, rd);
    chk("refusal err", {15'h0000, er}, {15'h0000, e});
    chk("refusal data", rd, 16'h0000);
  endtask : ref_chk

  task automatic field_put(input int un, input int t);
    rnd = {$urandom, $urandom};
    fld_data = rnd[$bits(fu_field_t)-1:0];
    fld_data.utype = fu_utype_t'(t[1:0]);
    if (t == 1) fld_data.position = 15'h7fff;
    if (t == 2) fld_data.position = 15'h0000;
    fld_unit = 6'(un);
    fld_we = 1'b1;
    if (un < FU_UNITS) fld_m[un] = fld_data;
    @(negedge clk);
    fld_we = 1'b0;
  endtask : field_put

  task automatic wr_cmd(input int k, input int un, input logic [15:0] v);
    i_host.xfer(1'b1, 1'b0, ad(cbase[k], un), v, ok, er, rd);
    cmd_m[k][un] = v;
    chk("cmd err", {15'h0000, er}, 16'h0000);
    chk("cmd level", {15'h0000, cmd_out[un][4-k]}, {15'h0000, v != 16'h0000});
  endtask : wr_cmd

  initial begin
    reset_n = 1'b0;
    proto_alt_pin = 1'b0;
    limit_readback_pin = 1'b0;
    fld_we = 1'b0;
    fld_unit = 6'h00;
    fld_data = '0;
    n_mismatch = 0;
    total_checks = 0;
    cbase = '{FU_OPEN_BASE, FU_STOP_BASE, FU_CLOSE_BASE, FU_SHUTDOWN_BASE, FU_STROKE_BASE};
    foreach (cmd_m[k, j]) cmd_m[k][j] = 16'h0000;
    void'($urandom(32'hd35f));
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 8; k++) field_put((k * 17) % 60, k);
    field_put(60, 0);
    for (int k = 0; k < 8; k++) begin
      u = (k * 17) % 60;
      exp_w = exp_alarm(fld_m[u]);
      rb_w = exp_rb(fld_m[u].relay);
      rd_chk("alarm word", 1'b0, ad(FU_ALARM_BASE, u), exp_w);
      rd_chk("feedback", 1'b0, ad(FU_FEEDBACK_BASE, u), {1'b0, fld_m[u].position});
      rd_chk("relay readback", 1'b0, ad(FU_RELAY_RB_BASE, u), rb_w);
      for (int b = 0; b < 16; b++) begin
        rd_chk("alarm bit", 1'b1, ad(FU_DISC_ALARM_BASE, 16 * u + b), {15'h0000, exp_w[b]});
        rd_chk("relay bit", 1'b1, ad(FU_DISC_RELAY_BASE, 16 * u + b), {15'h0000, rb_w[b]});
      end
    end
    i_host.idle();
    proto_alt_pin = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      u = (k * 17) % 60;
      rd_chk("alt feedback", 1'b0, ad(FU_FEEDBACK_BASE, u),
        {4'h0, fld_m[u].position[14:3]});
    end
    for (int k = 0; k < 5; k++) begin
      wr_cmd(k, 0, 16'hff00);
      wr_cmd(k, 59, 16'h0001);
      wr_cmd(k, 59, 16'h0000);
      wr_cmd(k, $urandom % 60, 16'($urandom));
    end
    for (int k = 0; k < 5; k++)
      for (int j = 0; j < FU_UNITS; j++) rd_chk("cmd word", 1'b0, ad(cbase[k], j), cmd_m[k][j]);
    for (int j = 0; j < 3; j++) begin
      u = (j * 59) / 2;
      rnd[15:0] = 16'($urandom);
      i_host.xfer(1'b1, 1'b0, ad(FU_DEMAND_BASE, u), rnd[15:0], ok, er, rd);
      chk("demand out", demand_out[u], rnd[15:0]);
      rd_chk("demand", 1'b0, ad(FU_DEMAND_BASE, u), rnd[15:0]);
    end
    i_host.idle();
    proto_alt_pin = 1'b0;
    limit_readback_pin = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      u = (k * 17) % 60;
      rd_chk("open limit", 1'b0, ad(FU_OPEN_BASE, u), {15'h0000, fld_m[u].open_limit});
      rd_chk("close limit", 1'b0, ad(FU_CLOSE_BASE, u), {15'h0000, fld_m[u].close_limit});
      rd_chk("stop word", 1'b0, ad(FU_STOP_BASE, u), cmd_m[1][u]);
    end
    i_host.idle();
    limit_readback_pin = 1'b0;
    repeat (3) @(negedge clk);
    ref_chk(1'b1, 1'b0, FU_ALARM_BASE, 1'b1);
    ref_chk(1'b1, 1'b0, FU_FEEDBACK_BASE, 1'b1);
    ref_chk(1'b1, 1'b0, FU_RELAY_RB_BASE, 1'b1);
    ref_chk(1'b1, 1'b1, FU_DISC_ALARM_BASE, 1'b1);
    ref_chk(1'b0, 1'b0, 16'h069f, 1'b1);
    ref_chk(1'b0, 1'b0, FU_MAP_END, 1'b1);
    ref_chk(1'b0, 1'b1, 16'h0b3f, 1'b1);
    ref_chk(1'b0, 1'b1, 16'h0f00, 1'b1);
    ref_chk(1'b0, 1'b1, 16'h167f, 1'b1);
    ref_chk(1'b0, 1'b1, 16'h1a40, 1'b1);
    ref_chk(1'b0, 1'b0, 16'h06dc, 1'b0);
    ref_chk(1'b1, 1'b0, 16'h0a60, 1'b0);
    ref_chk(1'b0, 1'b0, 16'h0a60, 1'b0);
    ref_chk(1'b0, 1'b0, 16'h0e1f, 1'b0);
    rd_chk("alarm kept", 1'b0, FU_ALARM_BASE, exp_alarm(fld_m[0]));
    rd_chk("feedback kept", 1'b0, FU_FEEDBACK_BASE, {1'b0, fld_m[0].position});
    i_host.idle();
    repeat (2) @(negedge clk);
    give_verdict();
  end

  // Tests take about 700 cycles; this cuts a hang.
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

endmodule : testbench

bind fu_map fu_map_chk i_chk (.clk(clk), .reset_n(reset_n), .host_req(host_req),
  .host_we(host_we), .host_discrete(host_discrete), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_ack(host_ack), .host_err(host_err),
  .host_rdata(host_rdata), .cmd_out(cmd_out), .demand_out(demand_out));

`default_nettype wire
